// ===== pcs_pkg.sv
// constants and types shared by the program-flow and pointer block
package pcs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W     = 13;
  localparam int TGT_W    = 11;
  localparam int LATCH_W  = 5;
  localparam int FP_W     = 8;
  localparam int DIR_W    = 7;
  localparam int MADDR_W  = 9;
  localparam int STK_N    = 8;
  localparam int STK_PW   = 3;
  localparam int WB_AW    = 5;

  // ----------------------------------------------------------------
  // register map, byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_PC_LOW  = 3'h0; // byte 0x00
  localparam logic [2:0] IDX_LATCH   = 3'h1; // byte 0x04
  localparam logic [2:0] IDX_FP      = 3'h2; // byte 0x08
  localparam logic [2:0] IDX_BANK    = 3'h3; // byte 0x0C

  // field positions in the bank control byte
  localparam int BANK_IND_POS = 7; // indirect bank bit
  localparam int BANK_DIR_HI  = 6; // direct bank select, bits 6:5
  localparam int BANK_DIR_LO  = 5;

  // paging: the top latch bit takes part in call and goto targets only if this is set
  localparam logic PAGE_HI_EN = 1'b0;

  // ----------------------------------------------------------------
  // reset values and fixed addresses
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0]    PC_RST      = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST   = 5'h00;
  localparam logic [FP_W-1:0]    FP_RST      = 8'h00;
  localparam logic [2:0]         BANK_RST    = 3'h0;
  localparam logic [STK_PW-1:0]  SP_RST      = 3'h0;
  localparam logic [PC_W-1:0]    IRQ_VECTOR  = 13'h0004;
  localparam logic [DIR_W-1:0]   IND_PORT    = 7'h00;
  localparam logic [FP_W-1:0]    FP_SELF     = 8'h00;

  // ----------------------------------------------------------------
  // program-flow commands from the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP    = 3'h0,
    OP_STEP   = 3'h1,
    OP_CALL   = 3'h2,
    OP_GOTO   = 3'h3,
    OP_RET    = 3'h4,
    OP_RETLIT = 3'h5,
    OP_RETINT = 3'h6,
    OP_IRQ    = 3'h7
  } pcs_op_t;

endpackage

// ===== pcs_stk_if.sv
// link between the program counter logic and the return stack
`timescale 1ns/100ps
`default_nettype none

interface pcs_stk_if;
  logic        push;
  logic        pop;
  logic [12:0] wdata;
  logic [12:0] top;

  modport ctl (output push, output pop, output wdata, input top);
  modport stk (input push, input pop, input wdata, output top);
endinterface

`default_nettype wire

// ===== pcs_stack.sv
// eight-entry circular return-address stack
`timescale 1ns/100ps
`default_nettype none

module pcs_stack
  import pcs_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  pcs_stk_if.stk     stk
);

  // ----------------------------------------------------------------
  // storage and pointer
  // ----------------------------------------------------------------
  logic [PC_W-1:0]   mem [STK_N];
  logic [STK_PW-1:0] sp_q;
  logic [STK_PW-1:0] sp_d;
  logic              wr_en;
  logic [STK_PW-1:0] top_idx;

  // pointer is never visible outside; wraps at eight with no flag
  always_comb
  begin
    sp_d    = sp_q;
    wr_en   = 1'b0;
    top_idx = sp_q - 3'h1;
    if (stk.push)
    begin
      wr_en = 1'b1;
      sp_d  = sp_q + 3'h1;
    end
    else if (stk.pop)
    begin
      sp_d = sp_q - 3'h1;
    end
  end

  // entries need no reset: pops beyond the pushes return old data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sp_q <= SP_RST;
    else
      sp_q <= sp_d;
    if (wr_en)
      mem[sp_q] <= stk.wdata;
  end

  assign stk.top = mem[top_idx];

endmodule

`default_nettype wire

// ===== pcs_top.sv
// program counter, paging, return stack and indirect pointer logic
`timescale 1ns/100ps
`default_nettype none

module pcs_top
  import pcs_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // classic wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [pcs_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // instruction decoder side
  input  wire pcs_pkg::pcs_op_t          op_i,
  input  wire logic [pcs_pkg::TGT_W-1:0] target_i,
  input  wire logic [pcs_pkg::DIR_W-1:0] mem_addr_i,
  input  wire logic                      mem_rd_i,
  input  wire logic                      mem_wr_i,
  output logic      [pcs_pkg::PC_W-1:0]  pc_o,
  output logic   [pcs_pkg::MADDR_W-1:0]  mem_addr_o,
  output logic                           mem_rd_o,
  output logic                           mem_wr_o,
  output logic                           mem_rdzero_o
);

  import pcs_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pcs_stk_if stk_if ();

  logic [PC_W-1:0]    pc_q,    pc_d;
  logic [LATCH_W-1:0] latch_q, latch_d;
  logic [FP_W-1:0]    fp_q,    fp_d;
  logic [2:0]         bank_q,  bank_d;
  logic               ack_q,   ack_d;
  logic [31:0]        rdat_q,  rdat_d;
  logic [MADDR_W-1:0] maddr_q, maddr_d;
  logic               mrd_q,   mrd_d;
  logic               mwr_q,   mwr_d;
  logic               mzero_q, mzero_d;

  logic               bus_req;
  logic               bus_wr;
  logic [2:0]         bus_idx;
  logic               pcl_wr;
  logic               latch_wr;
  logic [PC_W-1:0]    pc_inc;
  logic [PC_W-1:0]    call_tgt;
  logic               is_ind;
  logic               self_ptr;

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  pcs_stack u_stack (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .stk   (stk_if)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // request taken once; ack blocks the second sample of a held strobe
  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_idx  = wb_adr_i[4:2];
  assign pcl_wr   = bus_wr & (bus_idx == IDX_PC_LOW);
  assign latch_wr = bus_wr & (bus_idx == IDX_LATCH);

  // ----------------------------------------------------------------
  // program counter and stack control
  // ----------------------------------------------------------------
  assign pc_inc   = pc_q + 13'h0001;
  // page bits on top of the opcode field; bit 4 masked out
  assign call_tgt = {latch_q[4] & PAGE_HI_EN,
                     latch_q[3], target_i};

  // a bus write of the low byte wins over any decoder command
  always_comb
  begin
    pc_d             = pc_q;
    stk_if.push      = 1'b0;
    stk_if.pop       = 1'b0;
    stk_if.wdata     = pc_inc;
    if (pcl_wr)
      pc_d = {latch_q, wb_dat_i[7:0]};
    else
    begin
      case (op_i)
        OP_STEP: pc_d = pc_inc;
        OP_GOTO: pc_d = call_tgt;
        OP_CALL:
        begin
          stk_if.push  = 1'b1;
          stk_if.wdata = pc_inc;
          pc_d         = call_tgt;
        end
        OP_IRQ:
        begin
          // the interrupted instruction is resumed, so save it as is
          stk_if.push  = 1'b1;
          stk_if.wdata = pc_q;
          pc_d         = IRQ_VECTOR;
        end
        OP_RET, OP_RETLIT, OP_RETINT:
        begin
          stk_if.pop = 1'b1;
          pc_d       = stk_if.top;
        end
        default: pc_d = pc_q;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pc_q <= PC_RST;
    else
      pc_q <= pc_d;
  end

  // ----------------------------------------------------------------
  // software registers and bus answer
  // ----------------------------------------------------------------
  // stack traffic has no path into the latch
  always_comb
  begin
    latch_d = latch_q;
    fp_d    = fp_q;
    bank_d  = bank_q;
    ack_d   = bus_req;
    rdat_d  = rdat_q;
    if (latch_wr)
      latch_d = wb_dat_i[4:0];
    if (bus_wr && bus_idx == IDX_FP)
      fp_d = wb_dat_i[7:0];
    if (bus_wr && bus_idx == IDX_BANK)
      bank_d = wb_dat_i[7:5];
    if (bus_req)
    begin
      // the upper counter bits have no read path at all
      case (bus_idx)
        IDX_PC_LOW: rdat_d = {24'h000000, pc_q[7:0]};
        IDX_LATCH:  rdat_d = {27'h0000000, latch_q};
        IDX_FP:     rdat_d = {24'h000000, fp_q};
        IDX_BANK:   rdat_d = {24'h000000, bank_q, 5'h00};
        default:    rdat_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latch_q <= LATCH_RST;
      fp_q    <= FP_RST;
      bank_q  <= BANK_RST;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h00000000;
    end
    else
    begin
      latch_q <= latch_d;
      fp_q    <= fp_d;
      bank_q  <= bank_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // data address formation
  // ----------------------------------------------------------------
  assign is_ind   = (mem_addr_i == IND_PORT);
  assign self_ptr = is_ind & (fp_q == FP_SELF);

  // the port holds nothing; a self pointer reads zero, writes nothing
  always_comb
  begin
    if (is_ind)
      maddr_d = {bank_q[2], fp_q};
    else
      maddr_d = {bank_q[1:0], mem_addr_i};
    mzero_d = mem_rd_i & self_ptr;
    mrd_d   = mem_rd_i & ~self_ptr;
    mwr_d   = mem_wr_i & ~self_ptr;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      maddr_q <= 9'h000;
      mrd_q   <= 1'b0;
      mwr_q   <= 1'b0;
      mzero_q <= 1'b0;
    end
    else
    begin
      maddr_q <= maddr_d;
      mrd_q   <= mrd_d;
      mwr_q   <= mwr_d;
      mzero_q <= mzero_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pc_o         = pc_q;
  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rdat_q;
  assign mem_addr_o   = maddr_q;
  assign mem_rd_o     = mrd_q;
  assign mem_wr_o     = mwr_q;
  assign mem_rdzero_o = mzero_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic is_call;
  logic is_ret;
  assign is_call = (op_i == OP_CALL) & ~pcl_wr;
  assign is_ret  = (op_i == OP_RET || op_i == OP_RETLIT ||
                    op_i == OP_RETINT) & ~pcl_wr;

  call_target_a: assert property (is_call |=> pc_q == $past(call_tgt))
    else $error("call did not branch to paged target");
  call_save_a: assert property (is_call |=> stk_if.top == $past(pc_inc))
    else $error("call did not save return address");
  call_return_a: assert property (is_call ##1 is_ret |=>
      pc_q == $past(pc_q, 2) + 13'h0001)
    else $error("return did not restore full counter");
  irq_save_a: assert property ((op_i == OP_IRQ && !pcl_wr) |=>
      (pc_q == IRQ_VECTOR && stk_if.top == $past(pc_q)))
    else $error("vectoring lost the interrupted address");
  latch_keep_a: assert property ((is_call || is_ret) && !latch_wr |=>
      $stable(latch_q))
    else $error("stack traffic changed the latch");
  low_load_a: assert property (pcl_wr |=>
      pc_q == {$past(latch_q), $past(wb_dat_i[7:0])})
    else $error("low byte write did not load upper");
  page_mask_a: assert property (is_call |=> pc_q[12] == 1'b0)
    else $error("latch bit 4 reached the counter");
  self_read_a: assert property (mem_rd_i && self_ptr |=>
      mem_rdzero_o && !mem_rd_o)
    else $error("self indirect read not forced to zero");
  self_write_a: assert property (mem_wr_i && self_ptr |=> !mem_wr_o)
    else $error("self indirect write was stored");
  ind_addr_a: assert property (is_ind |=>
      mem_addr_o == {$past(bank_q[2]), $past(fp_q)})
    else $error("indirect address wrongly formed");
  dir_addr_a: assert property (!is_ind |=>
      mem_addr_o == {$past(bank_q[1:0]), $past(mem_addr_i)})
    else $error("direct address wrongly formed");
  reset_pc_a: assert property ($fell(rst_i) |-> pc_q == PC_RST)
    else $error("counter not cleared by reset");

  call_seen_c:  cover property (is_call ##[1:20] is_ret);
  irq_seen_c:   cover property (op_i == OP_IRQ ##[1:20]
                                op_i == OP_RETINT);
  self_rd_c:    cover property (mem_rd_i && self_ptr);
  low_wr_c:     cover property (pcl_wr ##1 op_i == OP_STEP);

endmodule

`default_nettype wire

// ===== pcs_dec_model.sv
// decoder and interrupt stand-in that feeds the block one command a cycle
`timescale 1ns/100ps
`default_nettype none

module pcs_dec_model
(
  input  wire logic                  clk_i,
  output var  pcs_pkg::pcs_op_t      op_o,
  output var  logic [pcs_pkg::TGT_W-1:0] target_o,
  output var  logic [pcs_pkg::DIR_W-1:0] mem_addr_o,
  output var  logic                  mem_rd_o,
  output var  logic                  mem_wr_o
);
  import pcs_pkg::*;

  // idle state at time zero
  initial
  begin
    op_o       = OP_NOP;
    target_o   = 11'h2AA;
    mem_addr_o = 7'h2A;
    mem_rd_o   = 1'b0;
    mem_wr_o   = 1'b0;
  end

  // unused fields flip to the inverse so a stale value is never trusted
  task automatic put(input pcs_op_t op, input logic [TGT_W-1:0] tgt,
                     input logic [DIR_W-1:0] ma, input logic rd,
                     input logic wr);
    @(posedge clk_i);
    op_o       <= op;
    target_o   <= (op == OP_CALL || op == OP_GOTO) ? tgt : ~target_o;
    mem_addr_o <= (rd || wr) ? ma : ~mem_addr_o;
    mem_rd_o   <= rd;
    mem_wr_o   <= wr;
  endtask
endmodule

`default_nettype wire

// ===== pcs_top_tb.sv
// self-checking bench for the program-flow and pointer block
`timescale 1ns/100ps
`default_nettype none

module pcs_top_tb;
  import pcs_pkg::*;

  typedef struct packed {
    logic [4:0]  latch;
    pcs_op_t     op;
    logic [10:0] tgt;
    logic [12:0] pc;
  } pcs_row_t;

  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          cyc   = 1'b0;
  logic          stb   = 1'b0;
  logic          we    = 1'b0;
  logic [4:0]    adr   = 5'h00;
  logic [3:0]    sel   = 4'hF;
  logic [31:0]   wdat  = 32'h0;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  pcs_op_t       dec_op;
  logic [10:0]   dec_tgt;
  logic [6:0]    dec_ma;
  logic          dec_rd;
  logic          dec_wr;
  logic [12:0]   pc_o;
  logic [8:0]    mem_addr_o;
  logic          mem_rd_o;
  logic          mem_wr_o;
  logic          mem_rdzero_o;
  logic [31:0]   q;
  logic [12:0]   e;
  int            err_count   = 0;
  int            check_count = 0;
  pcs_row_t      rows [4];

  always #50 clk_i = ~clk_i;

  pcs_dec_model dec_u (.clk_i(clk_i), .op_o(dec_op), .target_o(dec_tgt),
    .mem_addr_o(dec_ma), .mem_rd_o(dec_rd), .mem_wr_o(dec_wr));

  pcs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .op_i(dec_op), .target_i(dec_tgt), .mem_addr_i(dec_ma),
    .mem_rd_i(dec_rd), .mem_wr_i(dec_wr), .pc_o(pc_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_rdzero_o(mem_rdzero_o));

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // classic single cycle; ack and read data are taken at the rising edge
  // that sees ack high, and only then is the request released
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      // a slave that never answers ends the run as a mismatch
      err_count++;
      finish_test();
    end
    else
    begin
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask

  // one command, then idle; result is settled just after the idle edge
  task automatic run(input pcs_op_t op, input logic [10:0] t,
                     input logic [6:0] ma, input logic rd, input logic wr);
    dec_u.put(op, t, ma, rd, wr);
    dec_u.put(OP_NOP, 11'h0, 7'h0, 1'b0, 1'b0);
    #1;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    finish_test();
  end

  initial
  begin
    rows = '{'{5'h08, OP_GOTO, 11'h123, 13'h0923},
             '{5'h18, OP_GOTO, 11'h7FF, 13'h0FFF},
             '{5'h10, OP_CALL, 11'h001, 13'h0001},
             '{5'h00, OP_STEP, 11'h000, 13'h0002}};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("pc after reset", pc_o, 13'h0);
    wb(1'b0, 5'h08, 8'h00);
    chk("pointer reset", q, 32'h0);
    $display("test reset done");
    // paging table: latch bit 4 must not reach the counter
    foreach (rows[i])
    begin
      wb(1'b1, 5'h04, {3'h0, rows[i].latch});
      run(rows[i].op, rows[i].tgt, 7'h0, 1'b0, 1'b0);
      chk("branch pc", pc_o, rows[i].pc);
    end
    $display("test paging done");
    wb(1'b1, 5'h04, 8'h15);
    wb(1'b1, 5'h00, 8'hAB);
    #1;
    chk("pc low write", pc_o, 13'h15AB);
    wb(1'b0, 5'h00, 8'h00);
    chk("pc low read", q, 32'hAB);
    run(OP_IRQ, 11'h0, 7'h0, 1'b0, 1'b0);
    chk("vector", pc_o, IRQ_VECTOR);
    run(OP_RETINT, 11'h0, 7'h0, 1'b0, 1'b0);
    chk("irq return", pc_o, 13'h15AB);
    dec_u.put(OP_CALL, 11'h7AA, 7'h0, 1'b0, 1'b0);
    dec_u.put(OP_RETLIT, 11'h0, 7'h0, 1'b0, 1'b0);
    #1;
    chk("call pc", pc_o, 13'h07AA);
    run(OP_NOP, 11'h0, 7'h0, 1'b0, 1'b0);
    chk("call return", pc_o, 13'h15AC);
    $display("test call return done");
    // nine calls back to back, the ninth lands on the first call's slot
    for (int k = 0; k < 9; k++)
      dec_u.put(OP_CALL, 11'h10 * (k + 1), 7'h0, 1'b0, 1'b0);
    for (int k = 0; k < 9; k++)
    begin
      e = (k < 8) ? 13'h10 * (8 - k) + 13'h1 : 13'h0081;
      run(pcs_op_t'(OP_RET + k % 3), 11'h0, 7'h0, 1'b0, 1'b0);
      chk("pop pc", pc_o, e);
    end
    wb(1'b0, 5'h04, 8'h00);
    chk("latch kept", q, 32'h15);
    $display("test stack wrap done");
    wb(1'b1, 5'h08, 8'h20);
    wb(1'b1, 5'h0C, 8'hC0);
    run(OP_NOP, 11'h0, 7'h00, 1'b1, 1'b0);
    chk("indirect addr", mem_addr_o, 9'h120);
    chk("indirect rd", {mem_rd_o, mem_rdzero_o}, 2'b10);
    run(OP_NOP, 11'h0, 7'h55, 1'b0, 1'b1);
    chk("direct addr", mem_addr_o, 9'h155);
    chk("direct wr", mem_wr_o, 1'b1);
    wb(1'b1, 5'h08, 8'h00);
    run(OP_NOP, 11'h0, 7'h00, 1'b1, 1'b0);
    chk("self read", {mem_rd_o, mem_rdzero_o}, 2'b01);
    run(OP_NOP, 11'h0, 7'h00, 1'b0, 1'b1);
    chk("self write", mem_wr_o, 1'b0);
    $display("test data address done");
    wb(1'b1, 5'h14, 8'h5A);
    wb(1'b0, 5'h14, 8'h00);
    chk("unmapped read", q, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("pc mid reset", pc_o, 13'h0);
    $display("test unmapped and reset done");
    finish_test();
  end
endmodule

`default_nettype wire
